//--- hw/whd_pkg.sv
// Constants shared by the health watchdog design.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package whd_pkg;

    // Clock and supervision timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WINDOW_MS     = 300;
    localparam int unsigned WINDOW_TOL_MS = 50;
    localparam int unsigned WINDOW_CYC    =
        WINDOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned CLKSTOP_NS    = 1000;
    localparam int unsigned CLKSTOP_CYC   = CLKSTOP_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 25;
    localparam int unsigned CLKSTOP_W     = 8;

    // Window timers
    localparam int unsigned NUM_TMR  = 3;
    localparam int unsigned TMR_SELF = 0;
    localparam int unsigned TMR_SCAN = 1;
    localparam int unsigned TMR_OVR  = 2;

    // Register port
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;

    // Control register fields
    localparam int unsigned CTRL_RUN_BIT = 0;

    // Status register fields
    localparam int unsigned ST_HEALTH_BIT  = 0;
    localparam int unsigned ST_RUNLAMP_BIT = 1;
    localparam int unsigned ST_RUNMODE_BIT = 2;
    localparam int unsigned ST_SELFEXP_BIT = 3;
    localparam int unsigned ST_SCANEXP_BIT = 4;
    localparam int unsigned ST_OVR_BIT     = 5;
    localparam int unsigned ST_CLKSTP_BIT  = 6;

    // Interrupt status and mask fields
    localparam int unsigned IRQ_W         = 3;
    localparam int unsigned IRQ_FAIL_BIT  = 0;
    localparam int unsigned IRQ_CLKSTP_BIT = 1;
    localparam int unsigned IRQ_SCAN_BIT  = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic {
        MODE_STOP,
        MODE_RUN
    } whd_mode_e;

endpackage : whd_pkg

//--- hw/whd_tmr_if.sv
// Control and status of one supervision window timer.
// Assumes all signals belong to the single system clock domain.
`timescale 1ns/100ps
`default_nettype none
interface whd_tmr_if;
    logic restart;
    logic run;
    logic expired;

    modport ctl (output restart, output run, input expired);
    modport tmr (input restart, input run, output expired);
endinterface : whd_tmr_if
`default_nettype wire

//--- hw/whd_window_timer.sv
// Supervision window timer: expires after LIMIT counting cycles.
// Assumes restart and run are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module whd_window_timer
    import whd_pkg::*;
#(
    parameter int unsigned LIMIT = WINDOW_CYC
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    whd_tmr_if.tmr    t
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             expired;
    logic             next_expired;

    always_comb begin
        next_cnt     = cnt;
        next_expired = expired;
        if (t.restart) begin
            next_cnt     = '0;
            next_expired = 1'b0;
        end else if (t.run && !expired) begin
            if (cnt == LAST) begin
                next_expired = 1'b1;
            end else begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt     <= '0;
            expired <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            expired <= next_expired;
        end
    end

    assign t.expired = expired;

    a_restart_clears: assert property (@(posedge clk) disable iff (sys_rst)
        t.restart |=> (!expired && cnt == '0))
        else $error("timer not cleared by restart");
    a_window_length: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(expired) |-> ($past(cnt) == LAST && $past(t.run)))
        else $error("timer expired at wrong count");
endmodule : whd_window_timer
`default_nettype wire

//--- hw/whd_clk_monitor.sv
// Detects a stopped monitored system clock by its missing toggles.
// Assumes the monitored level is already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module whd_clk_monitor
    import whd_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic sysClkIn,
    output var  logic stopped
);
    localparam logic [CLKSTOP_W-1:0] LAST = CLKSTOP_W'(CLKSTOP_CYC - 1);

    logic                 prevLvl;
    logic [CLKSTOP_W-1:0] quiet;
    logic [CLKSTOP_W-1:0] next_quiet;
    logic                 next_stopped;

    always_comb begin
        next_quiet   = quiet;
        next_stopped = stopped;
        if (sysClkIn != prevLvl) begin
            next_quiet   = '0;
            next_stopped = 1'b0;
        end else if (quiet == LAST) begin
            next_stopped = 1'b1;
        end else begin
            next_quiet = quiet + CLKSTOP_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevLvl <= 1'b0;
            quiet   <= '0;
            stopped <= 1'b0;
        end else begin
            prevLvl <= sysClkIn;
            quiet   <= next_quiet;
            stopped <= next_stopped;
        end
    end

    a_toggle_clears: assert property (@(posedge clk) disable iff (sys_rst)
        (sysClkIn != prevLvl) |=> !stopped)
        else $error("stop flag held despite toggle");
endmodule : whd_clk_monitor
`default_nettype wire

//--- hw/whd_watchdog.sv
// CPU health watchdog: health and run lamps, forced stop, I/O reset.
// Assumes event pulses and levels are synchronous to clk.
//
// How it works
// - Health lamp stays lit while a self-test pass arrives in each window.
// - Health lamp goes dark once a window passes with no self-test pass.
// - A program pass longer than the window is a fault and darkens it.
// - A missed self-test or overrun forces STOP and resets the I/O chain.
// - Run lamp needs RUN mode, good health and a scan in each window.
// - Run lamp is off whenever the CPU is in STOP mode.
// - Health lamp ignores the mode and works in RUN and STOP alike.
// - A stopped system clock darkens the health lamp while it lasts.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module whd_watchdog
    import whd_pkg::*;
#(
    parameter int unsigned WINDOW_CYCLES = WINDOW_CYC
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              selfTestPass,
    input  wire logic              scanDone,
    input  wire logic              progBusy,
    input  wire logic              sysClkIn,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output var  logic [DATA_W-1:0] regRdData,
    output var  logic              healthLamp,
    output var  logic              runLamp,
    output var  logic              stopMode,
    output var  logic              ioChainRst,
    output var  logic              irq
);

    function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
        regHit = (a == off);
    endfunction : regHit

    whd_tmr_if tmr [NUM_TMR] ();

    logic [NUM_TMR-1:0] tmrExp;
    logic               clkStopped;

    // Supervision timers: self-test, scan and program overrun
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
            whd_window_timer #(
                .LIMIT (WINDOW_CYCLES)
            ) u_tmr (
                .clk     (clk),
                .sys_rst (sys_rst),
                .t       (tmr[gi])
            );
            assign tmrExp[gi] = tmr[gi].expired;
        end
    endgenerate

    whd_mode_e mode;
    whd_mode_e next_mode;

    // Single-cycle event pulses restart the windows
    assign tmr[TMR_SELF].restart = selfTestPass;
    assign tmr[TMR_SELF].run     = 1'b1;
    assign tmr[TMR_SCAN].restart = scanDone || (mode == MODE_STOP);
    assign tmr[TMR_SCAN].run     = (mode == MODE_RUN);
    // Overrun timer counts only while a program pass is in progress
    assign tmr[TMR_OVR].restart  = !progBusy;
    assign tmr[TMR_OVR].run      = progBusy;

    whd_clk_monitor u_clkmon (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .sysClkIn (sysClkIn),
        .stopped  (clkStopped)
    );

    logic failNow;
    logic failPrev;
    logic healthOk;
    logic scanOk;
    logic clkStopPrev;
    logic scanExpPrev;

    assign failNow  = tmrExp[TMR_SELF] || tmrExp[TMR_OVR];
    // Mode plays no part in health, so it holds in RUN and STOP
    assign healthOk = !failNow && !clkStopped;
    assign scanOk   = !tmrExp[TMR_SCAN];

    logic [IRQ_W-1:0]  irqStat;
    logic [IRQ_W-1:0]  irqMask;
    logic [IRQ_W-1:0]  next_irqStat;
    logic [IRQ_W-1:0]  next_irqMask;
    logic [IRQ_W-1:0]  irqEvent;
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] next_rdData;
    logic              next_healthLamp;
    logic              next_runLamp;
    logic              next_stopMode;
    logic              next_ioChainRst;
    logic              next_irq;

    always_comb begin
        statusWord                 = RD_ZERO;
        statusWord[ST_HEALTH_BIT]  = healthLamp;
        statusWord[ST_RUNLAMP_BIT] = runLamp;
        statusWord[ST_RUNMODE_BIT] = (mode == MODE_RUN);
        statusWord[ST_SELFEXP_BIT] = tmrExp[TMR_SELF];
        statusWord[ST_SCANEXP_BIT] = tmrExp[TMR_SCAN];
        statusWord[ST_OVR_BIT]     = tmrExp[TMR_OVR];
        statusWord[ST_CLKSTP_BIT]  = clkStopped;
    end

    // Mode, lamps and I/O reset
    always_comb begin
        next_mode = mode;
        if (regWr && regHit(regAddr, OFF_CTRL)) begin
            next_mode = regWrData[CTRL_RUN_BIT] ? MODE_RUN : MODE_STOP;
        end
        // Safety wins over a concurrent software RUN request
        if (failNow) begin
            next_mode = MODE_STOP;
        end
        next_stopMode   = (next_mode == MODE_STOP);
        next_ioChainRst = failNow && !failPrev;
        next_healthLamp = healthOk;
        // New mode, so the run lamp never lags stopMode by a cycle
        unique case (next_mode)
            MODE_RUN:  next_runLamp = healthOk && scanOk;
            MODE_STOP: next_runLamp = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode        <= MODE_STOP;
            stopMode    <= 1'b1;
            ioChainRst  <= 1'b0;
            healthLamp  <= 1'b0;
            runLamp     <= 1'b0;
            failPrev    <= 1'b0;
            clkStopPrev <= 1'b0;
            scanExpPrev <= 1'b0;
        end else begin
            mode        <= next_mode;
            stopMode    <= next_stopMode;
            ioChainRst  <= next_ioChainRst;
            healthLamp  <= next_healthLamp;
            runLamp     <= next_runLamp;
            failPrev    <= failNow;
            clkStopPrev <= clkStopped;
            scanExpPrev <= tmrExp[TMR_SCAN];
        end
    end

    // Interrupts: sticky, write one to clear, set beats clear
    always_comb begin
        irqEvent                 = '0;
        irqEvent[IRQ_FAIL_BIT]   = failNow && !failPrev;
        irqEvent[IRQ_CLKSTP_BIT] = clkStopped && !clkStopPrev;
        irqEvent[IRQ_SCAN_BIT]   = tmrExp[TMR_SCAN] && !scanExpPrev;
        next_irqStat = irqStat;
        next_irqMask = irqMask;
        if (regWr && regHit(regAddr, OFF_IRQ_STAT)) begin
            next_irqStat = irqStat & ~regWrData[IRQ_W-1:0];
        end
        if (regWr && regHit(regAddr, OFF_IRQ_MASK)) begin
            next_irqMask = regWrData[IRQ_W-1:0];
        end
        next_irqStat = next_irqStat | irqEvent;
        next_irq     = |(next_irqStat & next_irqMask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStat <= '0;
            irqMask <= IRQ_MASK_RST;
            irq     <= 1'b0;
        end else begin
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
            irq     <= next_irq;
        end
    end

    // Read port; data stand one cycle after the strobe only
    always_comb begin
        next_rdData = RD_ZERO;
        if (regRd) begin
            if (regHit(regAddr, OFF_CTRL)) begin
                next_rdData[CTRL_RUN_BIT] = (mode == MODE_RUN);
            end else if (regHit(regAddr, OFF_STATUS)) begin
                next_rdData = statusWord;
            end else if (regHit(regAddr, OFF_IRQ_STAT)) begin
                next_rdData[IRQ_W-1:0] = irqStat;
            end else if (regHit(regAddr, OFF_IRQ_MASK)) begin
                next_rdData[IRQ_W-1:0] = irqMask;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= RD_ZERO;
        end else begin
            regRdData <= next_rdData;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_fail_forces_stop: assert property (
        failNow |=> (stopMode && mode == MODE_STOP))
        else $error("fault did not force STOP");
    a_fail_io_reset: assert property (
        $rose(failNow) |=> ioChainRst ##1 !ioChainRst)
        else $error("I/O reset not a single pulse on fault");
    a_selftest_miss_dark: assert property (
        tmrExp[TMR_SELF] |=> !healthLamp)
        else $error("health lamp lit after missed self-test");
    a_overrun_dark: assert property (
        tmrExp[TMR_OVR] |=> !healthLamp)
        else $error("health lamp lit during overrun");
    a_clkstop_dark: assert property (
        clkStopped |=> !healthLamp)
        else $error("health lamp lit with clock stopped");
    a_health_any_mode: assert property (
        (!failNow && !clkStopped) |=> healthLamp)
        else $error("health lamp dark while healthy");
    a_stop_run_dark: assert property (
        stopMode |-> !runLamp)
        else $error("run lamp lit in STOP");
    a_run_lamp_on: assert property (
        (healthOk && scanOk) |=> (runLamp == !stopMode))
        else $error("run lamp dark in healthy RUN");
    a_scan_miss_dark: assert property (
        tmrExp[TMR_SCAN] |=> !runLamp)
        else $error("run lamp lit after missed scan");
    a_io_rst_stop: assert property (
        ioChainRst |-> stopMode)
        else $error("I/O reset without STOP");
    a_io_rst_quiet: assert property (
        !failNow |=> !ioChainRst)
        else $error("I/O reset without a fault");
    a_ovr_restart_idle: assert property (
        !progBusy |=> !tmrExp[TMR_OVR])
        else $error("overrun flagged while program idle");
    a_self_restart_clears: assert property (
        selfTestPass |=> !tmrExp[TMR_SELF])
        else $error("self-test pass did not restart window");
    a_scan_held_stop: assert property (
        (mode == MODE_STOP) |=> !tmrExp[TMR_SCAN])
        else $error("scan window expired in STOP");
    a_clkstop_keeps_mode: assert property (
        (clkStopped && !failNow && !regWr) |=> (mode == $past(mode)))
        else $error("clock stop changed the mode");
    a_mode_write_takes: assert property (
        (regWr && regHit(regAddr, OFF_CTRL) && !failNow)
            |=> (stopMode != $past(regWrData[CTRL_RUN_BIT])))
        else $error("mode write not taken");

    // Register port checks
    a_rd_idle_zero: assert property (
        !regRd |=> (regRdData == RD_ZERO))
        else $error("read data not zero after idle cycle");
    a_rd_ctrl_mode: assert property (
        (regRd && regHit(regAddr, OFF_CTRL))
            |=> (regRdData[CTRL_RUN_BIT] == $past(mode == MODE_RUN)))
        else $error("control read wrong");
    a_rd_status_bits: assert property (
        (regRd && regHit(regAddr, OFF_STATUS))
            |=> (regRdData[ST_HEALTH_BIT] == $past(healthLamp)
                && regRdData[ST_CLKSTP_BIT] == $past(clkStopped)))
        else $error("status read wrong");
    a_rd_irq_stat: assert property (
        (regRd && regHit(regAddr, OFF_IRQ_STAT))
            |=> (regRdData[IRQ_W-1:0] == $past(irqStat)))
        else $error("interrupt status read wrong");
    a_rd_mask_bits: assert property (
        (regRd && regHit(regAddr, OFF_IRQ_MASK))
            |=> (regRdData[IRQ_W-1:0] == $past(irqMask)))
        else $error("interrupt mask read wrong");

    // Interrupt checks; an event must never be lost to a clear
    a_irq_follows: assert property (
        (|(irqEvent & irqMask) && !(regWr && regHit(regAddr, OFF_IRQ_MASK)))
            |=> irq)
        else $error("interrupt low with unmasked status");
    a_fail_sets_irq: assert property (
        (failNow && !failPrev) |=> irqStat[IRQ_FAIL_BIT])
        else $error("fault onset not latched");
    a_irq_set_wins: assert property (
        (irqEvent != '0)
            |=> ((irqStat & $past(irqEvent)) == $past(irqEvent)))
        else $error("interrupt event lost to a clear");
    a_irq_w1c_clear: assert property (
        (regWr && regHit(regAddr, OFF_IRQ_STAT) && irqEvent == '0)
            |=> ((irqStat & $past(regWrData[IRQ_W-1:0])) == '0))
        else $error("write one did not clear status");
    a_irq_quiet_masked: assert property (
        (irqMask == '0 && !regWr) |=> !irq)
        else $error("interrupt raised while all masked");

endmodule : whd_watchdog
`default_nettype wire

//--- testbench/whd_seq_model.sv
// Model of the CPU sequencer: event pulses, program passes, clock.
// Assumes the bench steers it synchronously to clk.
`timescale 1ns/100ps
`default_nettype none
module whd_seq_model (
    input  wire logic       clk,
    input  wire logic       stEn,
    input  wire logic       scEn,
    input  wire logic       hang,
    input  wire logic       clkRun,
    input  wire logic [5:0] stGap,
    output var  logic       selfTestPass,
    output var  logic       scanDone,
    output var  logic       progBusy,
    output var  logic       sysClkIn
);
    logic [5:0] stCnt;
    logic [5:0] scCnt;

    initial begin
        {selfTestPass, scanDone, progBusy, sysClkIn} = 4'h0;
        {stCnt, scCnt} = 12'h000;
    end

    always @(posedge clk) begin
        // Events are single-cycle pulses only
        selfTestPass <= stEn && (stCnt >= stGap);
        scanDone     <= scEn && (scCnt == 6'h1D);
        stCnt <= (stCnt >= stGap) ? 6'h00 : stCnt + 6'h01;
        scCnt <= (scCnt == 6'h1D) ? 6'h00 : scCnt + 6'h01;
        // Short passes; hang stands for a runaway program
        progBusy <= hang || stCnt[2];
        // A stopped clock freezes at its last level
        if (clkRun) begin
            sysClkIn <= ~sysClkIn;
        end
    end
endmodule : whd_seq_model
`default_nettype wire

//--- testbench/cpu_health_watchdog_test.sv
// Self-checking bench for the health watchdog, short window.
// Assumes whd_pkg, the design files and the sequencer model.
`timescale 1ns/100ps
`default_nettype none
module cpu_health_watchdog_test;
    import whd_pkg::*;
    // Short window keeps the run brief
    localparam int unsigned WC = 50;
    logic              clk, sys_rst, selfTestPass, scanDone;
    logic              progBusy, sysClkIn, regWr, regRd, rdPend;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData;
    logic              healthLamp, runLamp, stopMode, ioChainRst, irq;
    logic              stEn, scEn, hang, clkRun;
    logic [5:0]        stGap;
    logic [DATA_W-1:0] expQ[$];
    int                err_total, checks_done, cyc, ioPulses, base;

    whd_watchdog #(.WINDOW_CYCLES(WC)) u_dut (.clk(clk),
        .sys_rst(sys_rst), .selfTestPass(selfTestPass),
        .scanDone(scanDone), .progBusy(progBusy), .sysClkIn(sysClkIn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .healthLamp(healthLamp),
        .runLamp(runLamp), .stopMode(stopMode), .ioChainRst(ioChainRst),
        .irq(irq));
    whd_seq_model u_seq (.clk(clk), .stEn(stEn), .scEn(scEn), .hang(hang),
        .clkRun(clkRun), .stGap(stGap), .selfTestPass(selfTestPass),
        .scanDone(scanDone), .progBusy(progBusy), .sysClkIn(sysClkIn));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // Read results appear one cycle after the strobe
    always @(posedge clk) begin
        rdPend <= regRd;
        cyc <= cyc + 1;
        if (ioChainRst === 1'b1) begin
            ioPulses <= ioPulses + 1;
        end
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    always @(negedge clk) begin
        if (rdPend === 1'b1) begin
            check("regRdData", regRdData, expQ.pop_front());
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] e);
        @(posedge clk);
        expQ.push_back(e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Let the edge's updates land before looking
    task automatic lamps(input logic h, input logic r, input logic s);
        #1;
        check("healthLamp", {31'h0, healthLamp}, {31'h0, h});
        check("runLamp", {31'h0, runLamp}, {31'h0, r});
        check("stopMode", {31'h0, stopMode}, {31'h0, s});
    endtask : lamps

    task automatic irqIs(input logic v);
        #1;
        check("irq", {31'h0, irq}, {31'h0, v});
    endtask : irqIs

    initial begin
        {regAddr, regWrData, regWr, regRd} = '0;
        {sys_rst, stEn, scEn, hang, clkRun} = 5'h19;
        stGap = 6'($urandom(32'h50BA4BF6) % 30 + 5);
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        lamps(1'b0, 1'b0, 1'b1);
        irqIs(1'b0);
        check("ioChainRst", {31'h0, ioChainRst}, 32'h0);
        // Healthy in STOP; unmapped place reads zero and ignores writes
        idle(120);
        lamps(1'b1, 1'b0, 1'b1);
        rd(OFF_STATUS, 32'h0000_0001);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, RD_ZERO);
        rd(OFF_CTRL, RD_ZERO);
        $display("Test 1 done");
        scEn <= 1'b1;
        stGap <= 6'($urandom_range(40, 5));
        wr(OFF_CTRL, 32'h0000_0001);
        idle(100);
        lamps(1'b1, 1'b1, 1'b0);
        rd(OFF_STATUS, 32'h0000_0007);
        $display("Test 2 done");
        wr(OFF_IRQ_MASK, 32'h0000_0004);
        scEn <= 1'b0;
        idle(80);
        lamps(1'b1, 1'b0, 1'b0);
        irqIs(1'b1);
        rd(OFF_IRQ_STAT, 32'h0000_0004);
        rd(OFF_STATUS, 32'h0000_0015);
        wr(OFF_IRQ_MASK, RD_ZERO);
        idle(2);
        irqIs(1'b0);
        wr(OFF_IRQ_STAT, 32'h0000_0004);
        rd(OFF_IRQ_STAT, RD_ZERO);
        scEn <= 1'b1;
        idle(100);
        lamps(1'b1, 1'b1, 1'b0);
        $display("Test 3 done");
        base = ioPulses;
        stEn <= 1'b0;
        idle(70);
        lamps(1'b0, 1'b0, 1'b1);
        check("ioPulses", ioPulses - base, 32'h1);
        rd(OFF_IRQ_STAT, 32'h0000_0001);
        // RUN is refused while the fault lasts
        wr(OFF_CTRL, 32'h0000_0001);
        idle(2);
        lamps(1'b0, 1'b0, 1'b1);
        stEn <= 1'b1;
        stGap <= 6'($urandom_range(40, 5));
        idle(60);
        lamps(1'b1, 1'b0, 1'b1);
        wr(OFF_CTRL, 32'h0000_0001);
        idle(60);
        lamps(1'b1, 1'b1, 1'b0);
        $display("Test 4 done");
        base = ioPulses;
        hang <= 1'b1;
        idle(70);
        lamps(1'b0, 1'b0, 1'b1);
        check("ioPulses", ioPulses - base, 32'h1);
        rd(OFF_STATUS, 32'h0000_0020);
        hang <= 1'b0;
        idle(10);
        wr(OFF_CTRL, 32'h0000_0001);
        idle(60);
        lamps(1'b1, 1'b1, 1'b0);
        $display("Test 5 done");
        clkRun <= 1'b0;
        idle(120);
        lamps(1'b0, 1'b0, 1'b0);
        rd(OFF_STATUS, 32'h0000_0044);
        rd(OFF_IRQ_STAT, 32'h0000_0003);
        clkRun <= 1'b1;
        idle(10);
        lamps(1'b1, 1'b1, 1'b0);
        wr(OFF_CTRL, RD_ZERO);
        idle(2);
        lamps(1'b1, 1'b0, 1'b1);
        $display("Test 6 done");
        idle(4);
        end_of_test();
    end
endmodule : cpu_health_watchdog_test
`default_nettype wire
